// >>> cpu_side_model.sv
// cpu side model: turns bench requests into instruction pulses
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic cpuClkEn,
    input  wire logic wantWait,
    input  wire logic wantStop,
    input  wire logic wantReturn,
    output logic      waitExec,
    output logic      stopExec,
    output logic      breakDone
);
    // instructions only execute while the cpu is clocked
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            waitExec  <= 1'b0;
            stopExec  <= 1'b0;
            breakDone <= 1'b0;
        end
        else
        begin
            waitExec  <= wantWait & cpuClkEn;
            stopExec  <= wantStop & cpuClkEn;
            breakDone <= wantReturn & cpuClkEn;
        end
    end
endmodule
`default_nettype wire

// >>> sim_counter.sv
// free-running prescale counter with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module sim_counter
    import sim_pkg::*;
#(
    parameter int WIDTH = CNT_W
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);

    if (WIDTH < 12)
    begin : g_width_check
        $error("counter too narrow for recovery timing");
    end

    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            overflow <= 1'b0;
        end
        else
        begin
            overflow <= &count;
        end
    end

endmodule
`default_nettype wire

// >>> sim_irq_status_break_lowpower_tb_top.sv
// testbench for the system integration unit
`timescale 1ns/10ps
`default_nettype none
module sim_irq_status_break_lowpower_tb_top
    import sim_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst;
    logic [ADDR_W-1:0] awAddr, arAddr;
    logic              awValid, awReady, wValid, wReady, bValid, bReady;
    logic              arValid, arReady, rValid, rReady;
    logic [31:0]       wData, rData;
    logic [1:0]        bResp, rResp, r;
    logic [15:0]       srcReq;
    logic [3:0]        resetSrc;
    logic              breakReq, breakDone, waitExec, stopExec;
    logic              resetOut, forceSoft, breakMode, clrEn, clrMask;
    logic              cpuClk, perClk, oscClk, lpExit, stackStart;
    logic              wdEn, wdTick, wantWait, wantStop, wantReturn;
    logic [31:0]       d;
    int                failures = 0;
    int                tests_run = 0;
    int                cycles = 0;
    int                n;
    // rows: source requests, then expected status one, two, three
    logic [39:0]       rows [7] = '{40'h0001_04_00_00, 40'h0020_80_00_00,
        40'h0040_00_01_00, 40'h2000_00_80_00, 40'h4000_00_00_01,
        40'h8000_00_00_02, 40'hffff_fc_ff_03};

    always #12.5 clk = ~clk;

    system_integration_unit system_integration_unit_inst (
        .clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .srcReq(srcReq), .resetSrc(resetSrc),
        .breakReq(breakReq), .breakDone(breakDone), .waitExec(waitExec),
        .stopExec(stopExec), .resetOut(resetOut),
        .forceSoftIrqVector(forceSoft), .breakMode(breakMode),
        .flagClearEnable(clrEn),
        .clearIntMask(clrMask), .cpuClkEn(cpuClk), .periphClkEn(perClk),
        .oscClkEn(oscClk), .lowpowerExit(lpExit), .stackStart(stackStart),
        .watchdogEnable(wdEn), .watchdogTick(wdTick));

    cpu_side_model cpu_side_model_inst (
        .clk(clk), .rst(rst), .cpuClkEn(cpuClk), .wantWait(wantWait),
        .wantStop(wantStop), .wantReturn(wantReturn), .waitExec(waitExec),
        .stopExec(stopExec), .breakDone(breakDone));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awAddr <= ADDR_W'({idx, 2'b00});
        wData <= {24'h0, v};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clk);
            if (!aw && awReady)
            begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (!w && wReady)
            begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        @(posedge clk);
        while (!bValid) @(posedge clk);
        r = bResp;
        bReady <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx);
        @(posedge clk);
        arAddr <= ADDR_W'({idx, 2'b00});
        arValid <= 1'b1;
        rReady <= 1'b1;
        @(posedge clk);
        while (!arReady) @(posedge clk);
        arValid <= 1'b0;
        @(posedge clk);
        while (!rValid) @(posedge clk);
        d = rData;
        r = rResp;
        rReady <= 1'b0;
    endtask

    task automatic pulse_break();
        @(posedge clk);
        breakReq <= 1'b1;
        @(posedge clk);
        breakReq <= 1'b0;
        @(negedge clk);
    endtask

    task automatic enter(input logic isStop);
        @(posedge clk);
        wantStop <= isStop;
        wantWait <= !isStop;
        @(posedge clk);
        wantStop <= 1'b0;
        wantWait <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        check("cpuClkEn", cpuClk, 0);
        check("clearIntMask", clrMask, 1);
        check("periphClkEn", perClk, !isStop);
        check("oscClkEn", oscClk, !isStop);
    endtask

    task automatic recover(input int exp);
        @(posedge clk);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (!lpExit && n < 5000);
        check("recovery", n, exp);
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        {awAddr, arAddr, wData, srcReq, resetSrc} = '0;
        {awValid, wValid, bReady, arValid, rReady, breakReq} = '0;
        {wantWait, wantStop, wantReturn} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("breakMode", breakMode, 0);
        check("flagClearEnable", clrEn, 1);
        check("watchdogEnable", wdEn, 1);
        rd(IDX_OPTIONS);
        check("options", d, 0);
        foreach (rows[i])
        begin
            srcReq <= rows[i][39:24];
            rd(IDX_STATUS_ONE);
            check("status_one", d, {24'h0, rows[i][23:16]});
            rd(IDX_STATUS_TWO);
            check("status_two", d, {24'h0, rows[i][15:8]});
            rd(IDX_STATUS_THREE);
            check("status_three", d, {24'h0, rows[i][7:0]});
        end
        wr(IDX_STATUS_ONE, 8'h00);
        check("status_bresp", r, RESP_OKAY);
        rd(IDX_STATUS_ONE);
        check("status_kept", d, 32'hfc);
        srcReq <= 16'h0000;
        rd(IDX_STATUS_TWO);
        check("status_clear", d, 0);
        rd(16'hfe0f);
        check("unmapped_rresp", r, RESP_DECERR);
        wr(16'hfe0f, 8'h01);
        check("unmapped_bresp", r, RESP_DECERR);
        pulse_break();
        check("forceSoftIrqVector", forceSoft, 1);
        check("breakMode", breakMode, 1);
        check("flagClearEnable", clrEn, 0);
        @(negedge clk);
        check("forceSoftIrqEnd", forceSoft, 0);
        wr(IDX_BRK_CTRL, 8'h80);
        @(negedge clk);
        check("flagClearEnable", clrEn, 1);
        wr(IDX_BRK_CTRL, 8'h00);
        @(negedge clk);
        check("flagClearEnable", clrEn, 0);
        @(posedge clk);
        wantReturn <= 1'b1;
        @(posedge clk);
        wantReturn <= 1'b0;
        repeat (2) @(negedge clk);
        check("breakModeEnd", breakMode, 0);
        check("flagClearEnable", clrEn, 1);
        enter(1'b0);
        @(posedge clk);
        srcReq <= 16'h0002;
        @(posedge clk);
        srcReq <= 16'h0000;
        @(negedge clk);
        check("cpuClkEn", cpuClk, 1);
        check("stackStart", stackStart, 1);
        check("lowpowerExit", lpExit, 1);
        enter(1'b0);
        pulse_break();
        check("lowpowerExit", lpExit, 1);
        check("stackStart", stackStart, 0);
        rd(IDX_BRK_STATUS);
        check("stopwait_status", d[STOPWAIT_STS_BIT], 1);
        wr(IDX_BRK_STATUS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            enter(1'b0);
            @(posedge clk);
            resetSrc <= 4'h1 << i;
            @(posedge clk);
            resetSrc <= 4'h0;
            @(negedge clk);
            check("resetOut", resetOut, 1);
            check("cpuClkEn", cpuClk, 1);
            check("stackStart", stackStart, 0);
            check("breakMode", breakMode, 0);
        end
        wr(IDX_OPTIONS, 8'h01);
        @(negedge clk);
        check("watchdogEnable", wdEn, 0);
        wr(IDX_OPTIONS, 8'h80);
        enter(1'b1);
        repeat (5) @(negedge clk);
        check("oscClkEn", oscClk, 0);
        @(posedge clk);
        srcReq <= 16'h0001;
        recover(RECOVER_SHORT + 1);
        check("stackStart", stackStart, 1);
        @(posedge clk);
        srcReq <= 16'h0000;
        wr(IDX_OPTIONS, 8'h00);
        enter(1'b1);
        @(posedge clk);
        breakReq <= 1'b1;
        @(posedge clk);
        breakReq <= 1'b0;
        recover(RECOVER_LONG);
        rd(IDX_BRK_STATUS);
        check("stopwait_status", d[STOPWAIT_STS_BIT], 1);
        check("watchdogEnable", wdEn, 1);
        enter(1'b0);
        n = 0;
        while (!wdTick && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
        check("watchdogTick", wdTick, 1);
        check("cpuClkEn", cpuClk, 0);
        @(negedge clk);
        check("watchdogTickEnd", wdTick, 0);
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> sim_pkg.sv
// constants and types shared by the system integration unit
package sim_pkg;

    localparam int ADDR_W = 20;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_STATUS_ONE   = 16'hfe04;
    localparam logic [15:0] IDX_STATUS_TWO   = 16'hfe05;
    localparam logic [15:0] IDX_STATUS_THREE = 16'hfe06;
    localparam logic [15:0] IDX_BRK_CTRL     = 16'hfe07;
    localparam logic [15:0] IDX_BRK_STATUS   = 16'hfe08;
    localparam logic [15:0] IDX_OPTIONS      = 16'hfe09;

    // field positions
    localparam int BRK_CLR_EN_BIT   = 7;
    localparam int STOPWAIT_STS_BIT = 1;
    localparam int SHORT_REC_BIT    = 7;
    localparam int WDOG_DIS_BIT     = 0;

    // reset values
    localparam logic [7:0] BRK_CTRL_RST   = 8'h00;
    localparam logic [7:0] BRK_STATUS_RST = 8'h00;
    localparam logic [7:0] OPTIONS_RST    = 8'h00;

    // timing counts in oscillator cycles
    localparam int CNT_W         = 13;
    localparam int RECOVER_LONG  = 4096;
    localparam int RECOVER_SHORT = 32;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_RECOVER
    } lp_state_t;

endpackage

// >>> system_integration_unit.sv
// interrupt status, break guard and low-power control
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module system_integration_unit
    import sim_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // sources, bit 0 is source one
    input  wire logic [15:0]       srcReq,
    input  wire logic [3:0]        resetSrc,
    input  wire logic              breakReq,
    input  wire logic              breakDone,
    input  wire logic              waitExec,
    input  wire logic              stopExec,
    // to cpu, clock generator, peripherals
    output logic                   resetOut,
    output logic                   forceSoftIrqVector,
    output logic                   breakMode,
    output logic                   flagClearEnable,
    output logic                   clearIntMask,
    output logic                   cpuClkEn,
    output logic                   periphClkEn,
    output logic                   oscClkEn,
    output logic                   lowpowerExit,
    output logic                   stackStart,
    output logic                   watchdogEnable,
    output logic                   watchdogTick
);

    localparam int ST_BOUND = RECOVER_SHORT;

    lp_state_t        state_q;
    lp_state_t        state_d;
    logic [7:0]       brkCtrl_q;
    logic [7:0]       options_q;
    logic             stopWaitSts_q;
    logic [CNT_W-1:0] count;
    logic             cntOverflow;
    logic             cntClear;
    logic             recoverDone;
    logic             anyReset;
    logic             irqPending;
    logic             awHeld_q;
    logic             wHeld_q;
    logic [15:0]      awIdx_q;
    logic [31:0]      wData_q;
    logic [3:0]       wStrb_q;
    logic             doWrite;
    logic [15:0]      wrIdx;
    logic [31:0]      wrData;
    logic [3:0]       wrStrb;
    logic             stopWaitClear;

    function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
        word_index = a[17:2];
    endfunction

    function automatic logic [7:0] status_byte(input logic [15:0] idx,
                                               input logic [15:0] req);
        case (idx)
            IDX_STATUS_ONE:   status_byte = {req[5:0], 2'h0};
            IDX_STATUS_TWO:   status_byte = req[13:6];
            IDX_STATUS_THREE: status_byte = {6'h00, req[15:14]};
            default:          status_byte = 8'h00;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [15:0] idx);
        is_mapped = (idx >= IDX_STATUS_ONE) && (idx <= IDX_OPTIONS);
    endfunction

    assign anyReset   = |resetSrc;
    assign irqPending = |srcReq;

    // write channel capture
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign wrIdx   = awHeld_q ? awIdx_q : word_index(s_axi_awaddr);
    assign wrData  = wHeld_q ? wData_q : s_axi_wdata;
    assign wrStrb  = wHeld_q ? wStrb_q : s_axi_wstrb;
    assign doWrite = (awHeld_q || (s_axi_awvalid && s_axi_awready))
                  && (wHeld_q || (s_axi_wvalid && s_axi_wready));

    always_ff @(posedge clk)
    begin
        if (rst || doWrite)
        begin
            awHeld_q <= 1'b0;
            awIdx_q  <= 16'h0000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_q <= 1'b1;
            awIdx_q  <= word_index(s_axi_awaddr);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || doWrite)
        begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wrIdx) ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // writable registers; status registers one to three ignore writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            brkCtrl_q <= BRK_CTRL_RST;
            options_q <= OPTIONS_RST;
        end
        else if (doWrite && wrStrb[0])
        begin
            if (wrIdx == IDX_BRK_CTRL)
            begin
                brkCtrl_q <= wrData[7:0];
            end
            if (wrIdx == IDX_OPTIONS)
            begin
                options_q <= wrData[7:0];
            end
        end
    end

    assign stopWaitClear = doWrite && wrStrb[0]
                        && (wrIdx == IDX_BRK_STATUS)
                        && !wrData[STOPWAIT_STS_BIT];

    // stop/wait break status, set wins over clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stopWaitSts_q <= BRK_STATUS_RST[STOPWAIT_STS_BIT];
        end
        else if (breakReq && (state_q == ST_WAIT || state_q == ST_STOP))
        begin
            stopWaitSts_q <= 1'b1;
        end
        else if (stopWaitClear)
        begin
            stopWaitSts_q <= 1'b0;
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(word_index(s_axi_araddr))
                            ? RESP_OKAY : RESP_DECERR;
            case (word_index(s_axi_araddr))
                IDX_BRK_CTRL:
                    s_axi_rdata <= {24'h000000, brkCtrl_q};
                IDX_BRK_STATUS:
                    s_axi_rdata <= {30'h0, stopWaitSts_q, 1'b0};
                IDX_OPTIONS:
                    s_axi_rdata <= {24'h000000, options_q};
                default:
                    s_axi_rdata <= {24'h000000,
                        status_byte(word_index(s_axi_araddr), srcReq)};
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // break handling
    always_ff @(posedge clk)
    begin
        if (rst || anyReset)
        begin
            breakMode      <= 1'b0;
            forceSoftIrqVector <= 1'b0;
        end
        else
        begin
            forceSoftIrqVector <= breakReq;
            if (breakReq)
            begin
                breakMode <= 1'b1;
            end
            else if (breakDone)
            begin
                breakMode <= 1'b0;
            end
        end
    end

    // peripherals gate every clear step with this level
    assign flagClearEnable = !breakMode
                          || brkCtrl_q[BRK_CLR_EN_BIT];

    // low-power sequencing
    sim_counter #(
        .WIDTH (CNT_W)
    ) sim_counter_inst (
        .clk      (clk),
        .rst      (rst),
        .clear    (cntClear),
        .count    (count),
        .overflow (cntOverflow)
    );

    assign cntClear = (state_q == ST_STOP)
                   || (state_q == ST_RUN && stopExec);
    assign recoverDone = options_q[SHORT_REC_BIT]
        ? (count == CNT_W'(RECOVER_SHORT - 1))
        : (count == CNT_W'(RECOVER_LONG - 1));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (!anyReset && stopExec)
                begin
                    state_d = ST_STOP;
                end
                else if (!anyReset && waitExec)
                begin
                    state_d = ST_WAIT;
                end
            ST_WAIT:
                if (anyReset || breakReq || irqPending)
                begin
                    state_d = ST_RUN;
                end
            ST_STOP:
                if (anyReset)
                begin
                    state_d = ST_RUN;
                end
                else if (breakReq || irqPending)
                begin
                    state_d = ST_RECOVER;
                end
            ST_RECOVER:
                if (anyReset || recoverDone)
                begin
                    state_d = ST_RUN;
                end
            default:
                state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clearIntMask <= 1'b0;
            lowpowerExit <= 1'b0;
            stackStart   <= 1'b0;
            resetOut     <= 1'b0;
        end
        else
        begin
            resetOut     <= anyReset;
            clearIntMask <= (state_q == ST_RUN) && !anyReset
                         && (waitExec || stopExec);
            lowpowerExit <= (state_q != ST_RUN) && (state_d == ST_RUN);
            stackStart   <= !anyReset && state_d == ST_RUN
                         && ((state_q == ST_WAIT && irqPending)
                          || (state_q == ST_RECOVER));
        end
    end

    assign cpuClkEn    = (state_q == ST_RUN);
    assign periphClkEn = (state_q == ST_RUN) || (state_q == ST_WAIT);
    assign oscClkEn    = (state_q != ST_STOP);

    assign watchdogEnable = !options_q[WDOG_DIS_BIT];
    assign watchdogTick   = cntOverflow && watchdogEnable
                         && (state_q == ST_RUN || state_q == ST_WAIT);

    // checks
    property p_status_one;
        @(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready
            && word_index(s_axi_araddr) == IDX_STATUS_ONE
        |=> s_axi_rvalid && s_axi_rdata[7:0] == {$past(srcReq[5:0]), 2'h0};
    endproperty
    a_status_one: assert property (p_status_one)
        else $error("status one read wrong");

    property p_status_two;
        @(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready
            && word_index(s_axi_araddr) == IDX_STATUS_TWO
        |=> s_axi_rdata[7:0] == $past(srcReq[13:6]);
    endproperty
    a_status_two: assert property (p_status_two)
        else $error("status two read wrong");

    property p_status_three;
        @(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready
            && word_index(s_axi_araddr) == IDX_STATUS_THREE
        |=> s_axi_rdata[7:0] == {6'h00, $past(srcReq[15:14])};
    endproperty
    a_status_three: assert property (p_status_three)
        else $error("status three read wrong");

    property p_break_vector;
        @(posedge clk) disable iff (rst)
        breakReq && !anyReset |=> forceSoftIrqVector && breakMode;
    endproperty
    a_break_vector: assert property (p_break_vector)
        else $error("break did not force vector");

    property p_flag_guard;
        @(posedge clk) disable iff (rst)
        breakMode && !brkCtrl_q[BRK_CLR_EN_BIT] && !doWrite
            && !breakDone && !anyReset |=> !flagClearEnable;
    endproperty
    a_flag_guard: assert property (p_flag_guard)
        else $error("flags not protected in break");

    sequence s_lowpower_entry;
        state_q == ST_RUN && !anyReset && (waitExec || stopExec);
    endsequence
    property p_mask_clear;
        @(posedge clk) disable iff (rst)
        s_lowpower_entry |=> clearIntMask && !cpuClkEn;
    endproperty
    a_mask_clear: assert property (p_mask_clear)
        else $error("low-power entry wrong");

    property p_wait_clocks;
        @(posedge clk) disable iff (rst)
        state_q == ST_WAIT |-> !cpuClkEn && periphClkEn;
    endproperty
    a_wait_clocks: assert property (p_wait_clocks)
        else $error("wait clock gating wrong");

    sequence s_wait_irq;
        state_q == ST_WAIT && irqPending && !anyReset;
    endsequence
    property p_wait_wake;
        @(posedge clk) disable iff (rst)
        s_wait_irq |=> lowpowerExit && stackStart && cpuClkEn;
    endproperty
    a_wait_wake: assert property (p_wait_wake)
        else $error("wait wake-up wrong");

    property p_stop_state;
        @(posedge clk) disable iff (rst)
        state_q == ST_STOP |-> !oscClkEn && !periphClkEn && count == '0;
    endproperty
    a_stop_state: assert property (p_stop_state)
        else $error("stop clocks or counter wrong");

    property p_stopwait_set;
        @(posedge clk) disable iff (rst)
        breakReq && (state_q == ST_WAIT || state_q == ST_STOP)
        |=> stopWaitSts_q;
    endproperty
    a_stopwait_set: assert property (p_stopwait_set)
        else $error("stop/wait break status not set");

    sequence s_short_recover_start;
        state_q == ST_STOP && state_d == ST_RECOVER
            && options_q[SHORT_REC_BIT];
    endsequence
    property p_short_recover;
        @(posedge clk) disable iff (rst || anyReset)
        s_short_recover_start |=> !stackStart ##ST_BOUND stackStart;
    endproperty
    a_short_recover: assert property (p_short_recover)
        else $error("short recovery length wrong");

    property p_watchdog_wait;
        @(posedge clk) disable iff (rst)
        state_q == ST_WAIT && cntOverflow && !options_q[WDOG_DIS_BIT]
        |-> watchdogTick;
    endproperty
    a_watchdog_wait: assert property (p_watchdog_wait)
        else $error("watchdog halted in wait");

endmodule
`default_nettype wire
